// ### src/pcm_link_pm_config.sv
// Purpose: Link power-management configuration register bank with capability mirror.
// Assumes: D3_STATE_I comes from power logic on the same clock.
// Notes:   Unmapped indices read zero and ignore writes, always with an ack.
module pcm_link_pm_config #(
   parameter int ADR_W = 10  // Word address width
) (
   input  wire logic        CLK_I,
   input  wire logic        RESET_I,
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [11:2] ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   input  wire logic        D3_STATE_I,
   output logic [31:0]      DAT_O,
   output logic             ACK_O,
   output logic             SEC_CLK_STOP_O,
   output logic             BEACON_WAKE_EN_O,
   output logic             PREFETCH_ONE_DW_O,
   output logic [2:0]       CAP_SHORT_IDLE_LAT_O,
   output logic [2:0]       CAP_DEEP_IDLE_LAT_O
);
   // Refuse every address width other than 10, the width of ADR_I
   if (ADR_W != 10) begin : g_bad_adr
      $error("ADR_W must be 10");
   end

   pcm_req_if req ();  // Access from front end

   logic [31:0] ctrl_q;        // Control register
   logic [31:0] ctrl_d;        // Next control value
   logic [31:0] lane_mask;     // Byte enables widened to bits
   logic [31:0] wr_mask;       // Bits a write may change
   logic [31:0] devcap;        // Capabilities view
   logic [31:0] aer_hdr;       // Error-reporting header view
   logic [31:0] rdat;          // Read multiplexer
   logic        ctrl_wr;       // Write to control
   logic        clk_stop_q;    // Secondary clock stop output
   logic        vc_enable;     // Virtual-channel enable view

   // Bus handshake
   pcm_wb_front u_front (
      .clk_i   (CLK_I),
      .reset_i (RESET_I),
      .cyc_i   (CYC_I),
      .stb_i   (STB_I),
      .we_i    (WE_I),
      .adr_i   (ADR_I),
      .sel_i   (SEL_I),
      .dat_i   (DAT_I),
      .ack_o   (ACK_O),
      .dat_o   (DAT_O),
      .req     (req)
   );

   // Byte lanes to bit mask, one lane per generate step
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign lane_mask[8*b +: 8] = {8{req.sel[b]}};
   end

   assign ctrl_wr = req.acc & req.we & (req.idx == pcm_pkg::CTRL_IDX);
   // Only writable bits pass; channel enable and reserved stay fixed
   assign wr_mask = lane_mask & pcm_pkg::CTRL_WMASK;

   // Merge write data under the mask
   always_comb begin
      ctrl_d = ctrl_q;
      if (ctrl_wr) begin
         ctrl_d = (ctrl_q & ~wr_mask) | (req.wdat & wr_mask);
      end
      ctrl_d[pcm_pkg::VC_EN_BIT] = pcm_pkg::VC_EN_FIXED;
   end

   // Control register storage; all latency codes reset to shortest bound
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         ctrl_q <= pcm_pkg::CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   assign vc_enable = ctrl_q[pcm_pkg::VC_EN_BIT];

   // Capabilities mirror of the two latency fields
   always_comb begin
      devcap = 32'h0000_0000;
      devcap[pcm_pkg::CAP_SHORT_LSB +: 3] = ctrl_q[pcm_pkg::SHORT_LAT_LSB +: 3];
      devcap[pcm_pkg::CAP_DEEP_LSB +: 3]  = ctrl_q[pcm_pkg::DEEP_LAT_LSB +: 3];
   end

   // Next-capability pointer follows the channel enable
   always_comb begin
      aer_hdr = 32'h0000_0000;
      aer_hdr[11:0] = vc_enable ? pcm_pkg::NEXT_CAP_VC : pcm_pkg::NEXT_CAP_NONE;
   end

   // Read multiplexer; unmapped indices read zero
   always_comb begin
      case (req.idx)
         pcm_pkg::CTRL_IDX:    rdat = ctrl_q;
         pcm_pkg::DEVCAP_IDX:  rdat = devcap;
         pcm_pkg::AER_HDR_IDX: rdat = aer_hdr;
         default:              rdat = 32'h0000_0000;
      endcase
   end
   assign req.rdat = rdat;

   // Clock stop only while the device sits in D3 and software allows it
   // Registered so the clock gate never sees a decode glitch
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         clk_stop_q <= 1'b0;
      end else begin
         clk_stop_q <= ctrl_q[pcm_pkg::CLK_STOP_BIT] & D3_STATE_I;
      end
   end

   // Outputs come straight from register bits
   assign SEC_CLK_STOP_O       = clk_stop_q;
   assign BEACON_WAKE_EN_O     = ctrl_q[pcm_pkg::BEACON_BIT];
   assign PREFETCH_ONE_DW_O    = ctrl_q[pcm_pkg::PREFETCH_DIS_BIT];
   assign CAP_SHORT_IDLE_LAT_O = ctrl_q[pcm_pkg::SHORT_LAT_LSB +: 3];
   assign CAP_DEEP_IDLE_LAT_O  = ctrl_q[pcm_pkg::DEEP_LAT_LSB +: 3];

   // Write to the control register with a given lane
   sequence s_ctrl_write(int lane);
      req.acc && req.we && req.idx == pcm_pkg::CTRL_IDX && req.sel[lane];
   endsequence

   // Write to a read-only index
   sequence s_ro_write;
      req.acc && req.we && req.idx != pcm_pkg::CTRL_IDX;
   endsequence

   // Reset leaves every field at its default
   chk_reset_defaults: assert property (@(posedge CLK_I)
      RESET_I |=> ctrl_q == 32'h0000_0000 && !BEACON_WAKE_EN_O && !PREFETCH_ONE_DW_O)
      else $error("control not cleared by reset");

   // Short-idle field follows a write of lane 2 and mirrors to capabilities
   chk_short_lat_write: assert property (@(posedge CLK_I) disable iff (RESET_I)
      s_ctrl_write(2) |=> CAP_SHORT_IDLE_LAT_O == $past(req.wdat[18:16])
                          && devcap[8:6] == $past(req.wdat[18:16]))
      else $error("short-idle latency not written or mirrored");

   // Deep-idle field follows a write of lane 1 and mirrors to capabilities
   chk_deep_lat_write: assert property (@(posedge CLK_I) disable iff (RESET_I)
      s_ctrl_write(1) |=> CAP_DEEP_IDLE_LAT_O == $past(req.wdat[15:13])
                          && devcap[11:9] == $past(req.wdat[15:13]))
      else $error("deep-idle latency not written or mirrored");

   // Top short-idle code is held as written
   chk_code_range: assert property (@(posedge CLK_I) disable iff (RESET_I)
      s_ctrl_write(2) && req.wdat[18:16] == pcm_pkg::SHORT_OVER_4US
      |=> ##1 CAP_SHORT_IDLE_LAT_O == pcm_pkg::SHORT_OVER_4US || $changed(ctrl_q))
      else $error("top latency code lost");

   // Channel enable never sets, whatever is written
   chk_vc_fixed_zero: assert property (@(posedge CLK_I) disable iff (RESET_I)
      s_ctrl_write(1) && req.wdat[12] |=> ctrl_q[12] == 1'b0)
      else $error("channel enable bit changed");

   // Header reads the empty pointer while the channel is off
   chk_next_cap_off: assert property (@(posedge CLK_I) disable iff (RESET_I)
      req.acc && !req.we && req.idx == pcm_pkg::AER_HDR_IDX
      |=> ##0 ACK_O && DAT_O[11:0] == 12'h000)
      else $error("next-capability pointer wrong");

   // Clock stop follows enable and D3 one cycle later, both ways
   chk_clk_stop_d3: assert property (@(posedge CLK_I) disable iff (RESET_I)
      ##1 SEC_CLK_STOP_O == ($past(ctrl_q[11]) && $past(D3_STATE_I)))
      else $error("secondary clock stop mismatch");

   // Writes to read-only indices leave the control register alone
   chk_ro_no_change: assert property (@(posedge CLK_I) disable iff (RESET_I)
      s_ro_write |=> $stable(ctrl_q))
      else $error("read-only write changed control");

   // Reserved control bits stay zero
   chk_reserved_zero: assert property (@(posedge CLK_I) disable iff (RESET_I)
      (ctrl_q & ~pcm_pkg::CTRL_WMASK) == 32'h0000_0000)
      else $error("reserved control bits set");

   // Read of control returns the beacon and prefetch bits one cycle on
   chk_ctrl_readback: assert property (@(posedge CLK_I) disable iff (RESET_I)
      req.acc && !req.we && req.idx == pcm_pkg::CTRL_IDX
      |=> ACK_O && DAT_O[10] == BEACON_WAKE_EN_O && DAT_O[19] == PREFETCH_ONE_DW_O)
      else $error("control readback mismatch");
endmodule : pcm_link_pm_config

// ### src/pcm_pkg.sv
// Purpose: Constants for the link power-management configuration register bank.
// Assumes: Classic Wishbone slave with 32-bit data and word addressing on ADR_I[11:2].
// Notes:   Register indices double as word addresses; byte address is four times the index.
package pcm_pkg;
   // Register indices (word addresses)
   localparam logic [9:0]  CTRL_IDX       = 10'h000;
   localparam logic [9:0]  DEVCAP_IDX     = 10'h094;
   localparam logic [9:0]  AER_HDR_IDX    = 10'h102;
   // Control register field positions
   localparam int          PREFETCH_DIS_BIT = 19;
   localparam int          SHORT_LAT_LSB    = 16;
   localparam int          DEEP_LAT_LSB     = 13;
   localparam int          VC_EN_BIT        = 12;
   localparam int          CLK_STOP_BIT     = 11;
   localparam int          BEACON_BIT       = 10;
   // Capabilities register field positions
   localparam int          CAP_SHORT_LSB    = 6;
   localparam int          CAP_DEEP_LSB     = 9;
   // Writable bits of the control register
   localparam logic [31:0] CTRL_WMASK     = 32'h000f_ec00;
   // Reset values
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
   localparam logic        VC_EN_FIXED    = 1'h0;
   // Next-capability offsets chosen by the channel enable
   localparam logic [11:0] NEXT_CAP_NONE  = 12'h000;
   localparam logic [11:0] NEXT_CAP_VC    = 12'h150;
   // Latency code meanings
   localparam logic [2:0]  SHORT_LT_64NS  = 3'h0;
   localparam logic [2:0]  SHORT_512_1US  = 3'h4;
   localparam logic [2:0]  SHORT_2_4US    = 3'h6;
   localparam logic [2:0]  SHORT_OVER_4US = 3'h7;
   localparam logic [2:0]  DEEP_LT_1US    = 3'h0;
   localparam logic [2:0]  DEEP_32_64US   = 3'h6;
   localparam logic [2:0]  DEEP_OVER_64US = 3'h7;
   // Wishbone front-end states
   typedef enum logic [1:0] {
      FE_IDLE = 2'b01,
      FE_ACK  = 2'b10
   } pcm_fe_state_t;
endpackage : pcm_pkg

// ### src/pcm_req_if.sv
// Purpose: Carries one register access from the bus front end to the register bank.
// Assumes: Single clock; acc is a one-cycle pulse.
// Notes:   rdat is combinational from the bank and sampled by the front end.
interface pcm_req_if;
   logic        acc;   // Access strobe, one cycle
   logic        we;    // Write when high
   logic [9:0]  idx;   // Register index
   logic [3:0]  sel;   // Byte lanes
   logic [31:0] wdat;  // Write data
   logic [31:0] rdat;  // Read data for idx
   modport front (output acc, output we, output idx, output sel, output wdat, input rdat);
   modport regs  (input acc, input we, input idx, input sel, input wdat, output rdat);
endinterface : pcm_req_if

// ### src/pcm_wb_front.sv
// Purpose: Classic Wishbone slave handshake for the register bank.
// Assumes: Master holds the request until it samples ACK_O high.
// Notes:   Answer comes one cycle after the request; a new request is taken in the cycle right after each ack.
module pcm_wb_front (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [9:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic             ack_o,
   output logic [31:0]      dat_o,
   pcm_req_if.front         req
);
   pcm_pkg::pcm_fe_state_t state_q;  // Handshake state
   logic                   ack_q;    // Registered acknowledge
   logic [31:0]            dat_q;    // Registered read data

   // Only a fresh request in idle makes an access, so a held request acts once
   assign req.acc  = (state_q == pcm_pkg::FE_IDLE) & cyc_i & stb_i;
   assign req.we   = we_i;
   assign req.idx  = adr_i;
   assign req.sel  = sel_i;
   assign req.wdat = dat_i;
   assign ack_o    = ack_q;
   assign dat_o    = dat_q;

   // Handshake sequencing
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q <= pcm_pkg::FE_IDLE;
      end else begin
         case (state_q)
            pcm_pkg::FE_IDLE: begin
               if (req.acc) begin
                  state_q <= pcm_pkg::FE_ACK;
               end
            end
            pcm_pkg::FE_ACK: begin
               // Ack lasts one cycle; master must release before the next access
               state_q <= pcm_pkg::FE_IDLE;
            end
            default: begin
               state_q <= pcm_pkg::FE_IDLE;
            end
         endcase
      end
   end

   // Acknowledge pulse
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req.acc;
      end
   end

   // Read data capture, zero for writes to keep the bus quiet
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         dat_q <= 32'h0000_0000;
      end else if (req.acc) begin
         dat_q <= req.we ? 32'h0000_0000 : req.rdat;
      end
   end

   // One access per acknowledge
   chk_ack_single: assert property (@(posedge clk_i) disable iff (reset_i)
      ack_q |=> !ack_q)
      else $error("ack held longer than one cycle");
endmodule : pcm_wb_front

// ### tb/pcie_link_pm_config_tb.sv
// Purpose: Self-checking bench for the link power-management register bank.
// Assumes: One-cycle Wishbone answer; DAT_O holds until the next access.
// Notes:   Random data from a fixed seed; every latency code walked in a loop.
module pcie_link_pm_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLK_I          = 1'b0;         // 25 MHz bench clock
   logic        RESET_I        = 1'b1;         // Held high from time zero
   logic        CYC_I          = 1'b0;         // Bus cycle
   logic        STB_I          = 1'b0;         // Bus strobe
   logic        WE_I           = 1'b0;         // Write when high
   logic [11:2] ADR_I          = 10'h000;      // Register index
   logic [3:0]  SEL_I          = 4'h0;         // Byte lanes
   logic [31:0] DAT_I          = 32'h0000_0000; // Write data
   logic        D3_STATE_I     = 1'b0;         // Power state input
   logic [31:0] DAT_O;                         // Read data
   logic        ACK_O;                         // Acknowledge pulse
   logic        SEC_CLK_STOP_O;                // Secondary clock stop
   logic        BEACON_WAKE_EN_O;              // Wake mechanism select
   logic        PREFETCH_ONE_DW_O;             // Single-doubleword fetch
   logic [2:0]  CAP_SHORT_IDLE_LAT_O;          // Mirrored short-idle code
   logic [2:0]  CAP_DEEP_IDLE_LAT_O;           // Mirrored deep-idle code
   int          num_errors     = 0;            // Mismatches seen
   int          check_count    = 0;            // Comparisons made
   logic [31:0] ctrl_m         = 32'h0000_0000; // Bench copy of the control word
   logic [31:0] rd;                            // Last read data
   logic [31:0] wd;                            // Scratch write data
   // Bits that software may change: 19:13 and 11:10, never 12
   localparam logic [31:0] WR_BITS = 32'h000f_ec00;

   // Free-running clock, 40 ns period
   // Reference clock never stops, even with secondary clocks stopped in D3
   always #20 CLK_I = ~CLK_I;

   pcm_link_pm_config #(.ADR_W(10)) DUT (
      .CLK_I(CLK_I), .RESET_I(RESET_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
      .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .D3_STATE_I(D3_STATE_I),
      .DAT_O(DAT_O), .ACK_O(ACK_O), .SEC_CLK_STOP_O(SEC_CLK_STOP_O),
      .BEACON_WAKE_EN_O(BEACON_WAKE_EN_O), .PREFETCH_ONE_DW_O(PREFETCH_ONE_DW_O),
      .CAP_SHORT_IDLE_LAT_O(CAP_SHORT_IDLE_LAT_O), .CAP_DEEP_IDLE_LAT_O(CAP_DEEP_IDLE_LAT_O));

   // Byte lanes expanded to a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : lane_mask

   // Capabilities word: deep code at 11:9, short code at 8:6
   function automatic logic [31:0] devcap_exp(input logic [31:0] c);
      return {20'h0_0000, c[15:13], c[18:16], 6'h00};
   endfunction : devcap_exp

   // Verdict; also the landing place of a timeout
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   // Single comparison point, four-state exact
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // Classic cycle: hold until ack is sampled high, release on that edge
   task automatic wb_access(input logic we, input logic [9:0] idx, input logic [3:0] sel,
                            input logic [31:0] wdat, output logic [31:0] rdat);
      int n;
      @(posedge CLK_I);
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      WE_I  <= we;
      ADR_I <= idx;
      SEL_I <= sel;
      DAT_I <= wdat;
      n = 0;
      // Values read right after the edge are those the edge sampled
      do begin
         @(posedge CLK_I);
         n++;
      end while (ACK_O !== 1'b1 && n < 20);
      if (ACK_O !== 1'b1) begin
         num_errors++;
         $display("[FAIL] %0t ns: no acknowledge", $time);
         conclude();
      end else begin
         // Data taken and request dropped at the very edge that saw ack
         rdat = DAT_O;
         CYC_I <= 1'b0;
         STB_I <= 1'b0;
      end
   endtask : wb_access

   // Write the control word and follow it in the bench copy
   task automatic write_ctrl(input logic [3:0] sel, input logic [31:0] d);
      logic [31:0] m;
      m = lane_mask(sel) & WR_BITS;
      wb_access(1'b1, pcm_pkg::CTRL_IDX, sel, d, rd);
      ctrl_m = (ctrl_m & ~m) | (d & m);
   endtask : write_ctrl

   // Read one word and compare
   task automatic read_check(input logic [9:0] idx, input logic [31:0] exp);
      wb_access(1'b0, idx, 4'hf, 32'h0000_0000, rd);
      check(rd, exp);
   endtask : read_check

   // Settled level outputs against the bench copy
   task automatic check_outputs();
      @(negedge CLK_I);
      check({31'h0, PREFETCH_ONE_DW_O}, {31'h0, ctrl_m[19]});
      check({29'h0, CAP_SHORT_IDLE_LAT_O}, {29'h0, ctrl_m[18:16]});
      check({29'h0, CAP_DEEP_IDLE_LAT_O}, {29'h0, ctrl_m[15:13]});
      check({31'h0, BEACON_WAKE_EN_O}, {31'h0, ctrl_m[10]});
      check({31'h0, SEC_CLK_STOP_O}, {31'h0, ctrl_m[11] & D3_STATE_I});
   endtask : check_outputs

   // Main sequence
   initial begin
      void'($urandom(32'h5af22882));
      repeat (4) @(posedge CLK_I);
      RESET_I <= 1'b0;
      check_outputs();
      read_check(pcm_pkg::CTRL_IDX, 32'h0000_0000);
      read_check(pcm_pkg::DEVCAP_IDX, 32'h0000_0000);
      read_check(pcm_pkg::AER_HDR_IDX, 32'h0000_0000);
      $display("Test reset_values done");
      // Every code in both fields, junk in reserved bits and the channel enable
      for (int c = 0; c < 8; c++) begin
         wd = $urandom | 32'h0000_1000;
         wd[18:16] = c[2:0];
         wd[15:13] = 3'h7 - c[2:0];
         write_ctrl(4'hf, wd);
         check(rd, 32'h0000_0000);
         read_check(pcm_pkg::CTRL_IDX, ctrl_m);
         read_check(pcm_pkg::DEVCAP_IDX, devcap_exp(ctrl_m));
         check_outputs();
      end
      $display("Test latency_codes done");
      // Random lanes, data and power state
      repeat (24) begin
         @(posedge CLK_I);
         D3_STATE_I <= 1'($urandom_range(0, 1));
         write_ctrl(4'($urandom_range(0, 15)), $urandom);
         read_check(pcm_pkg::CTRL_IDX, ctrl_m);
         read_check(pcm_pkg::AER_HDR_IDX, 32'h0000_0000);
         check_outputs();
      end
      $display("Test random_lanes done");
      // Clock stop: each combination of enable and D3
      for (int k = 0; k < 4; k++) begin
         write_ctrl(4'h2, k[0] ? 32'h0000_0800 : 32'h0000_0000);
         @(posedge CLK_I);
         D3_STATE_I <= k[1];
         repeat (3) @(posedge CLK_I);
         check_outputs();
      end
      $display("Test clock_stop done");
      // Read-only and unmapped places ignore writes
      wb_access(1'b1, 10'h3ff, 4'hf, 32'hffff_ffff, rd);
      read_check(10'h3ff, 32'h0000_0000);
      wb_access(1'b1, pcm_pkg::DEVCAP_IDX, 4'hf, 32'hffff_ffff, rd);
      read_check(pcm_pkg::DEVCAP_IDX, devcap_exp(ctrl_m));
      wb_access(1'b1, pcm_pkg::AER_HDR_IDX, 4'hf, 32'hffff_ffff, rd);
      read_check(pcm_pkg::AER_HDR_IDX, 32'h0000_0000);
      read_check(pcm_pkg::CTRL_IDX, ctrl_m);
      $display("Test read_only done");
      // Second reset in mid-run clears every field
      write_ctrl(4'hf, 32'hffff_ffff);
      @(posedge CLK_I);
      RESET_I <= 1'b1;
      repeat (2) @(posedge CLK_I);
      RESET_I <= 1'b0;
      ctrl_m = 32'h0000_0000;
      check_outputs();
      read_check(pcm_pkg::CTRL_IDX, 32'h0000_0000);
      $display("Test mid_reset done");
      conclude();
   end
endmodule : pcie_link_pm_config_tb
